// [src/exu_defs.svh]
// constants for the exception entry and context switch unit
`ifndef EXU_DEFS_SVH
`define EXU_DEFS_SVH

// ****************************************
// supervision word field positions
// ****************************************
`define EXU_SW_SUP      0
`define EXU_SW_TICK     1
`define EXU_SW_INTR     2
`define EXU_SW_DTR      5
`define EXU_SW_ITR      6
`define EXU_SW_CE       13
`define EXU_SW_DLY      14
`define EXU_SW_IDX_LO   28
`define EXU_SW_IDX_HI   31
`define EXU_SW_RESET    32'h0000_0001

// ****************************************
// special register word addresses
// ****************************************
`define EXU_A_SW        16'h0011
`define EXU_G_PCS       12'h002
`define EXU_G_EAS       12'h003
`define EXU_G_STS       12'h004
`define EXU_A_CSW       16'h0080
`define EXU_A_SH_PCS    16'h0090
`define EXU_A_SH_STS    16'h0091
`define EXU_A_SH_EAS    16'h0092

// ****************************************
// context switch register fields and pc step
// ****************************************
`define EXU_CSW_RUN_LO  16
`define EXU_CSW_RESET   16'h0000
`define EXU_INSN_BYTES  32'h0000_0004

// ****************************************
// vector offsets
// ****************************************
`define EXU_V_RST   32'h0000_0100
`define EXU_V_BUS   32'h0000_0200
`define EXU_V_DPF   32'h0000_0300
`define EXU_V_IPF   32'h0000_0400
`define EXU_V_TICK  32'h0000_0500
`define EXU_V_ALIGN 32'h0000_0600
`define EXU_V_ILL   32'h0000_0700
`define EXU_V_INT   32'h0000_0800
`define EXU_V_DTLB  32'h0000_0900
`define EXU_V_ITLB  32'h0000_0A00
`define EXU_V_RANGE 32'h0000_0B00
`define EXU_V_SYS   32'h0000_0C00
`define EXU_V_FPE   32'h0000_0D00
`define EXU_V_TRAP  32'h0000_0E00

`endif

// [src/exu_pkg.sv]
// types shared by the exception entry and context switch unit
package exu_pkg;

    // causes listed from highest to lowest priority
    typedef enum logic [3:0] {
        EXU_RST, EXU_ITLB, EXU_IPF, EXU_IBUS, EXU_ILL, EXU_ALIGN,
        EXU_DTLB, EXU_SYS, EXU_TRAP, EXU_DPF, EXU_DBUS, EXU_RANGE,
        EXU_FPE, EXU_TICK, EXU_INT, EXU_NONE
    } exu_cause_t;

    // pipeline state that comes with an exception request
    typedef struct packed {
        logic [31:0] cur_pc;   // address of the faulting instruction
        logic [31:0] next_pc;  // next not executed instruction
        logic [31:0] fetch_ea; // instruction fetch address
        logic [31:0] lsu_ea;   // load/store address
        logic        in_delay; // instruction sits in a delay slot
    } exu_ctx_t;

    // move-to / move-from special register access
    typedef struct packed {
        logic        we;
        logic        re;
        logic [15:0] addr;
        logic [31:0] wdata;
    } exu_spr_t;

endpackage : exu_pkg

// [src/exu_core.sv]
// exception entry, return and fast context switch logic
`include "exu_defs.svh"

// Operation
// - save current or next pc per cause
// - delay slot saves pc-4, sets flag
// - copy whole status word to save set
// - save set by context index, else zero
// - fault causes except range and trap load address save register
// - fixed priority among simultaneous causes
// - fault causes save faulting or jump address
// - interrupt-like causes save next or jump
// - address source is fetch or load/store
// - increment context index per new exception
// - index overflow raises range exception instead
// - no fast switching when enable clear
// - entry clears translation, interrupts, sets supervisor
// - return restores status, pc, decrements index
// - context switch completes in one cycle
// - switch register: run index, set selector
// - switch register only reachable in supervisor
// - run index write switches immediately
// - entry moves run index to selector, clears
// - selector picks other context shadow set
// - shadow access only in supervisor mode
// - switch register shared by all contexts
// - jump to vector of taken cause
module exu_core #(
    parameter int NCTX = 16               // shadow register sets
) (
    input  wire logic              clk_sys,    // core clock
    input  wire logic              resetn,     // async reset, low
    input  wire logic [14:0]       exc_req,    // pending causes, by priority
    input  exu_pkg::exu_ctx_t      exc_ctx,    // pc and address context
    input  wire logic              rfe,        // return from exception
    input  exu_pkg::exu_spr_t      spr,        // special register access
    output logic [14:0]            exc_ack,    // one-hot cause taken now
    output logic                   exc_valid,  // redirect valid, pulse
    output logic [31:0]            exc_vector, // redirect target offset
    output exu_pkg::exu_cause_t    exc_cause,  // cause last taken
    output logic                   rfe_valid,  // return redirect, pulse
    output logic [31:0]            rfe_pc,     // restored program counter
    output logic [31:0]            supervision_word, // live status word
    output logic [15:0]            running_context,  // active context id
    output logic [31:0]            spr_rdata,  // read data
    output logic                   spr_ack,    // access answered, pulse
    output logic                   spr_denied  // access refused, pulse
);

    localparam int IW = $clog2(NCTX);     // save set index width

    // ****************************************
    // state
    // ****************************************
    logic [31:0] sw_q;                    // supervision word
    logic [15:0] run_q;                   // running context field
    logic [15:0] sel_q;                   // register set selector field
    logic [31:0] pcs_q [NCTX];            // exception pc save sets
    logic [31:0] sts_q [NCTX];            // exception status save sets
    logic [31:0] eas_q [NCTX];            // exception address save sets
    logic [31:0] vec_q;                   // redirect target
    logic        vld_q;                   // redirect pulse
    exu_pkg::exu_cause_t cause_q;         // last cause
    logic [31:0] rpc_q;                   // return target
    logic        rvld_q;                  // return pulse
    logic [31:0] rd_q;                    // read data
    logic        ack_q;                   // access answered
    logic        den_q;                   // access refused

    // ****************************************
    // helpers
    // ****************************************
    // vector offset of a cause
    function automatic logic [31:0] vec_of(input exu_pkg::exu_cause_t c);
        unique case (c)
            exu_pkg::EXU_RST:   vec_of = `EXU_V_RST;
            exu_pkg::EXU_ITLB:  vec_of = `EXU_V_ITLB;
            exu_pkg::EXU_IPF:   vec_of = `EXU_V_IPF;
            exu_pkg::EXU_IBUS:  vec_of = `EXU_V_BUS;
            exu_pkg::EXU_ILL:   vec_of = `EXU_V_ILL;
            exu_pkg::EXU_ALIGN: vec_of = `EXU_V_ALIGN;
            exu_pkg::EXU_DTLB:  vec_of = `EXU_V_DTLB;
            exu_pkg::EXU_SYS:   vec_of = `EXU_V_SYS;
            exu_pkg::EXU_TRAP:  vec_of = `EXU_V_TRAP;
            exu_pkg::EXU_DPF:   vec_of = `EXU_V_DPF;
            exu_pkg::EXU_DBUS:  vec_of = `EXU_V_BUS;
            exu_pkg::EXU_RANGE: vec_of = `EXU_V_RANGE;
            exu_pkg::EXU_FPE:   vec_of = `EXU_V_FPE;
            exu_pkg::EXU_TICK:  vec_of = `EXU_V_TICK;
            exu_pkg::EXU_INT:   vec_of = `EXU_V_INT;
            exu_pkg::EXU_NONE:  vec_of = `EXU_V_RST;
        endcase
    endfunction

    // true when a special register address hits a save group
    function automatic logic grp_hit(input logic [15:0] a,
                                     input logic [11:0] g);
        grp_hit = (a[15:4] == g) && (32'(a[3:0]) < NCTX);
    endfunction

    // ****************************************
    // cause selection
    // ****************************************
    logic [14:0]         req_m;           // requests after masking
    exu_pkg::exu_cause_t pick;            // highest priority request
    exu_pkg::exu_cause_t take;            // cause actually taken
    logic                ce;              // fast switching enabled
    logic [3:0]          idx;             // current context index
    logic                idx_full;        // index cannot grow
    logic [IW-1:0]       set_i;           // save set for this entry
    logic                taking;          // an exception is taken now

    assign ce  = sw_q[`EXU_SW_CE];
    assign idx = sw_q[`EXU_SW_IDX_HI:`EXU_SW_IDX_LO];
    assign idx_full = (32'(idx) >= NCTX - 1);

    // tick and external interrupt obey their accept flags
    always_comb
    begin
        req_m = exc_req;
        req_m[exu_pkg::EXU_TICK] = exc_req[exu_pkg::EXU_TICK] & sw_q[`EXU_SW_TICK];
        req_m[exu_pkg::EXU_INT]  = exc_req[exu_pkg::EXU_INT] & sw_q[`EXU_SW_INTR];
    end

    // lowest index wins; others stay pending at the input
    always_comb
    begin
        pick = exu_pkg::EXU_NONE;
        for (int i = 14; i >= 0; i--)
        begin
            if (req_m[i])
            begin
                pick = exu_pkg::exu_cause_t'(4'(i));
            end
        end
    end

    // overflow of the index turns the entry into a range exception
    always_comb
    begin
        take = pick;
        if (pick != exu_pkg::EXU_NONE && pick != exu_pkg::EXU_RST && ce && idx_full)
        begin
            take = exu_pkg::EXU_RANGE;
        end
    end

    assign taking = (pick != exu_pkg::EXU_NONE);

    // one-hot answer to the requester that won
    always_comb
    begin
        exc_ack = '0;
        if (taking)
        begin
            exc_ack[pick] = 1'b1;
        end
    end

    // save set follows the index only with switching on
    assign set_i = ce ? idx[IW-1:0] : '0;

    // ****************************************
    // values saved on entry
    // ****************************************
    logic        fault_cls;               // cause saves faulting address
    logic        ea_cls;                  // cause loads address save
    logic [31:0] pc_sv;                   // pc to save
    logic [31:0] ea_sv;                   // effective address to save

    always_comb
    begin
        fault_cls = 1'b0;
        ea_cls    = 1'b0;
        ea_sv     = exc_ctx.lsu_ea;
        unique case (take)
            exu_pkg::EXU_ITLB, exu_pkg::EXU_IPF, exu_pkg::EXU_IBUS, exu_pkg::EXU_ILL:
            begin
                fault_cls = 1'b1;
                ea_cls    = 1'b1;
                ea_sv     = exc_ctx.fetch_ea;
            end
            exu_pkg::EXU_ALIGN, exu_pkg::EXU_DTLB, exu_pkg::EXU_DPF, exu_pkg::EXU_DBUS:
            begin
                fault_cls = 1'b1;
                ea_cls    = 1'b1;
            end
            exu_pkg::EXU_RANGE, exu_pkg::EXU_TRAP:
            begin
                fault_cls = 1'b1;
            end
            default:
            begin
                fault_cls = 1'b0;                 // next-instruction causes
            end
        endcase
    end

    // delay slot saves the jump before it in every class
    always_comb
    begin
        if (exc_ctx.in_delay)
        begin
            pc_sv = exc_ctx.cur_pc - `EXU_INSN_BYTES;
        end
        else if (fault_cls)
        begin
            pc_sv = exc_ctx.cur_pc;
        end
        else
        begin
            pc_sv = exc_ctx.next_pc;
        end
    end

    logic entry;                          // entry that saves state
    assign entry = taking && take != exu_pkg::EXU_RST;

    // ****************************************
    // special register decode
    // ****************************************
    logic          sup;                   // supervisor mode
    logic          acc;                   // access requested
    logic          wr_ok;                 // permitted write
    logic [IW-1:0] a_i;                   // direct set index
    logic [IW-1:0] sh_i;                  // shadow set from selector

    assign sup   = sw_q[`EXU_SW_SUP];
    assign acc   = spr.we | spr.re;
    assign wr_ok = spr.we & sup;
    assign a_i   = spr.addr[IW-1:0];
    assign sh_i  = sel_q[IW-1:0];

    // ****************************************
    // save register sets, one per context
    // ****************************************
    for (genvar g = 0; g < NCTX; g++)
    begin : g_set
        // entry saves into the set of the current index
        always_ff @(posedge clk_sys or negedge resetn)
        begin
            if (!resetn)
            begin
                pcs_q[g] <= 32'h0000_0000;
                sts_q[g] <= 32'h0000_0000;
                eas_q[g] <= 32'h0000_0000;
            end
            else if (entry && 32'(set_i) == g)
            begin
                pcs_q[g] <= pc_sv;
                sts_q[g] <= sw_q;
                if (ea_cls)
                begin
                    eas_q[g] <= ea_sv;
                end
            end
            else if (wr_ok && !taking)
            begin
                if (grp_hit(spr.addr, `EXU_G_PCS) && 32'(a_i) == g
                    || spr.addr == `EXU_A_SH_PCS && 32'(sh_i) == g)
                begin
                    pcs_q[g] <= spr.wdata;
                end
                if (grp_hit(spr.addr, `EXU_G_STS) && 32'(a_i) == g
                    || spr.addr == `EXU_A_SH_STS && 32'(sh_i) == g)
                begin
                    sts_q[g] <= spr.wdata;
                end
                if (grp_hit(spr.addr, `EXU_G_EAS) && 32'(a_i) == g
                    || spr.addr == `EXU_A_SH_EAS && 32'(sh_i) == g)
                begin
                    eas_q[g] <= spr.wdata;
                end
            end
        end
    end

    // ****************************************
    // supervision word
    // ****************************************
    logic [IW-1:0] ret_i;                 // set restored on return
    logic [3:0]    idx_dn;                // index after return

    assign idx_dn = (idx == 4'h0) ? 4'h0 : idx - 4'h1;
    assign ret_i  = ce ? idx_dn[IW-1:0] : '0;

    // entry forces a safe state, return restores, else software write
    always_ff @(posedge clk_sys or negedge resetn)
    begin
        if (!resetn)
        begin
            sw_q <= `EXU_SW_RESET;
        end
        else if (taking && take == exu_pkg::EXU_RST)
        begin
            sw_q <= `EXU_SW_RESET;
        end
        else if (entry)
        begin
            sw_q[`EXU_SW_DTR]  <= 1'b0;
            sw_q[`EXU_SW_ITR]  <= 1'b0;
            sw_q[`EXU_SW_TICK] <= 1'b0;
            sw_q[`EXU_SW_INTR] <= 1'b0;
            sw_q[`EXU_SW_SUP]  <= 1'b1;
            sw_q[`EXU_SW_DLY]  <= exc_ctx.in_delay;
            if (ce && !idx_full)
            begin
                sw_q[`EXU_SW_IDX_HI:`EXU_SW_IDX_LO] <= idx + 4'h1;
            end
        end
        else if (rfe)
        begin
            sw_q <= sts_q[ret_i];
            if (ce)
            begin
                sw_q[`EXU_SW_IDX_HI:`EXU_SW_IDX_LO] <= idx_dn;
            end
        end
        else if (wr_ok && spr.addr == `EXU_A_SW)
        begin
            sw_q <= spr.wdata;
        end
    end

    // ****************************************
    // context switch register, one for all contexts
    // ****************************************
    always_ff @(posedge clk_sys or negedge resetn)
    begin
        if (!resetn)
        begin
            run_q <= `EXU_CSW_RESET;
            sel_q <= `EXU_CSW_RESET;
        end
        else if (entry && ce)
        begin
            sel_q <= run_q;
            run_q <= 16'h0000;                    // main context
        end
        else if (wr_ok && !rfe && spr.addr == `EXU_A_CSW)
        begin
            run_q <= spr.wdata[31:`EXU_CSW_RUN_LO];
            sel_q <= spr.wdata[`EXU_CSW_RUN_LO-1:0];
        end
    end

    // ****************************************
    // redirect outputs
    // ****************************************
    always_ff @(posedge clk_sys or negedge resetn)
    begin
        if (!resetn)
        begin
            vec_q   <= `EXU_V_RST;
            vld_q   <= 1'b0;
            cause_q <= exu_pkg::EXU_NONE;
            rpc_q   <= 32'h0000_0000;
            rvld_q  <= 1'b0;
        end
        else
        begin
            vld_q  <= taking;
            rvld_q <= rfe && !taking;
            if (taking)
            begin
                vec_q   <= vec_of(take);
                cause_q <= take;
            end
            if (rfe && !taking)
            begin
                rpc_q <= pcs_q[ret_i];
            end
        end
    end

    // ****************************************
    // special register read port
    // ****************************************
    logic [31:0] rd_d;                    // selected read value

    always_comb
    begin
        rd_d = 32'h0000_0000;
        if (spr.addr == `EXU_A_SW)
        begin
            rd_d = sw_q;
        end
        else if (spr.addr == `EXU_A_CSW)
        begin
            rd_d = {run_q, sel_q};
        end
        else if (grp_hit(spr.addr, `EXU_G_PCS))
        begin
            rd_d = pcs_q[a_i];
        end
        else if (grp_hit(spr.addr, `EXU_G_STS))
        begin
            rd_d = sts_q[a_i];
        end
        else if (grp_hit(spr.addr, `EXU_G_EAS))
        begin
            rd_d = eas_q[a_i];
        end
        else if (spr.addr == `EXU_A_SH_PCS)
        begin
            rd_d = pcs_q[sh_i];
        end
        else if (spr.addr == `EXU_A_SH_STS)
        begin
            rd_d = sts_q[sh_i];
        end
        else if (spr.addr == `EXU_A_SH_EAS)
        begin
            rd_d = eas_q[sh_i];
        end
    end

    // user-mode accesses answer zero and flag the refusal
    always_ff @(posedge clk_sys or negedge resetn)
    begin
        if (!resetn)
        begin
            rd_q  <= 32'h0000_0000;
            ack_q <= 1'b0;
            den_q <= 1'b0;
        end
        else
        begin
            ack_q <= acc;
            den_q <= acc && !sup;
            rd_q  <= (spr.re && sup) ? rd_d : 32'h0000_0000;
        end
    end

    // ****************************************
    // output wiring
    // ****************************************
    assign exc_valid        = vld_q;
    assign exc_vector       = vec_q;
    assign exc_cause        = cause_q;
    assign rfe_valid        = rvld_q;
    assign rfe_pc           = rpc_q;
    assign supervision_word = sw_q;
    assign running_context  = run_q;
    assign spr_rdata        = rd_q;
    assign spr_ack          = ack_q;
    assign spr_denied       = den_q;

endmodule // exu_core

// [tb/exu_core_sva.sv]
// port checker for the exception entry unit
// ****
// checker
// ****
module exu_core_sva #(
    parameter int NCTX = 16                    // shadow sets
) (
    input wire logic         clk_sys,          // clock
    input wire logic         resetn,           // reset, low
    input wire logic [14:0]  exc_req,          // pending
    input exu_pkg::exu_ctx_t exc_ctx,          // context
    input wire logic         rfe,              // return
    input exu_pkg::exu_spr_t spr,              // access
    input wire logic [14:0]  exc_ack,          // taken
    input wire logic         exc_valid,        // redirect
    input wire logic [31:0]  exc_vector,       // target
    input wire logic         rfe_valid,        // returned
    input wire logic [31:0]  supervision_word, // status
    input wire logic [15:0]  running_context,  // run field
    input wire logic [31:0]  spr_rdata,        // read data
    input wire logic         spr_ack,          // answered
    input wire logic         spr_denied        // refused
);
    timeunit 1ns;
    timeprecision 1ns;
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (!resetn);
    wire       take = |exc_ack;              // a cause taken
    wire       ent  = take & ~exc_ack[0];    // non-reset entry
    wire [3:0] idx  = supervision_word[31:28]; // nesting index

    AST_ONEHOT: assert property ($onehot0(exc_ack))
        else $error("several causes taken");
    AST_PRIO: assert property (take |-> ((exc_ack - 15'h1) & exc_req
        & {1'b1, supervision_word[1], 13'h1FFF}) == 15'h0)
        else $error("higher cause passed over");
    AST_TAKE: assert property (exc_req[12:0] != 13'h0 |-> take)
        else $error("pending cause not taken");
    AST_VALID: assert property (take |=> exc_valid)
        else $error("no redirect after take");
    AST_RSTV: assert property (exc_ack[0] |=> exc_vector == 32'h0000_0100
        && supervision_word == 32'h0000_0001)
        else $error("reset entry wrong");
    AST_SAFE: assert property (ent |=> (supervision_word & 32'h0000_0067) == 32'h1)
        else $error("entry status not safe");
    AST_DSX: assert property (ent |=> supervision_word[14] == $past(exc_ctx.in_delay))
        else $error("delay flag wrong");
    AST_CID: assert property (ent && supervision_word[13] && idx < NCTX - 1
        |=> idx == $past(idx) + 4'h1 && running_context == 16'h0)
        else $error("index not advanced");
    AST_OVF: assert property (ent && supervision_word[13] && idx >= NCTX - 1
        |=> exc_vector == 32'h0000_0B00 && idx == $past(idx))
        else $error("overflow not refused");
    AST_NOCE: assert property (ent && !supervision_word[13] |=> idx == $past(idx))
        else $error("index moved while off");
    AST_RFE: assert property (rfe && !take |=> rfe_valid)
        else $error("return not answered");
    AST_SPR: assert property (spr.we || spr.re
        |=> spr_ack && spr_denied == !$past(supervision_word[0]))
        else $error("access answer wrong");
    AST_DENY: assert property (spr_denied |-> spr_rdata == 32'h0)
        else $error("refused read leaked data");
endmodule // exu_core_sva

bind exu_core exu_core_sva #(.NCTX(NCTX)) u_sva (
    .clk_sys(clk_sys), .resetn(resetn), .exc_req(exc_req), .exc_ctx(exc_ctx), .rfe(rfe),
    .spr(spr), .exc_ack(exc_ack), .exc_valid(exc_valid), .exc_vector(exc_vector),
    .rfe_valid(rfe_valid), .supervision_word(supervision_word),
    .running_context(running_context), .spr_rdata(spr_rdata), .spr_ack(spr_ack),
    .spr_denied(spr_denied));

// [tb/exu_pipe_model.sv]
// pipeline model that raises exception causes
module exu_pipe_model (
    input  wire logic        clk_sys, // clock
    input  wire logic        resetn,  // reset, low
    input  wire logic [14:0] raise,   // new causes, pulse
    input  wire logic [14:0] exc_ack, // taken cause
    output logic      [14:0] exc_req  // pending, level
);
    timeunit 1ns;
    timeprecision 1ns;
    // hold each cause until taken
    always_ff @(posedge clk_sys or negedge resetn)
    begin
        if (!resetn)
            exc_req <= 15'h0;
        else
            exc_req <= (exc_req & ~exc_ack) | raise;
    end
endmodule // exu_pipe_model

// [tb/exception_entry_and_context_switch_bench.sv]
// bench for the exception entry unit
`include "exu_defs.svh"
module exception_entry_and_context_switch_bench;
    timeunit 1ns;
    timeprecision 1ns;
    logic              clk_sys = 1'b0, resetn = 1'b0, rfe = 1'b0;
    logic [14:0]       raise = 15'h0, exc_req, exc_ack;
    exu_pkg::exu_ctx_t exc_ctx = '0;
    exu_pkg::exu_spr_t spr = '0;
    logic              exc_valid, rfe_valid, spr_ack, spr_denied, dq;
    logic [31:0]       exc_vector, rfe_pc, sw, spr_rdata, q, epc, exception_address_save = 32'h0;
    logic [15:0]       run_ctx;
    exu_pkg::exu_cause_t exc_cause;
    int                mismatches = 0, comparisons = 0;
    logic [3:0]        vec_k [15] = '{1, 10, 4, 2, 7, 6, 9, 12, 14, 3, 2, 11, 13, 5, 8};
    always #50 clk_sys = ~clk_sys;
    exu_pipe_model u_pipe (.clk_sys(clk_sys), .resetn(resetn), .raise(raise),
        .exc_ack(exc_ack), .exc_req(exc_req));
    exu_core #(.NCTX(16)) u_dut (.clk_sys(clk_sys), .resetn(resetn), .exc_req(exc_req),
        .exc_ctx(exc_ctx), .rfe(rfe), .spr(spr), .exc_ack(exc_ack), .exc_valid(exc_valid),
        .exc_vector(exc_vector), .exc_cause(exc_cause), .rfe_valid(rfe_valid),
        .rfe_pc(rfe_pc), .supervision_word(sw), .running_context(run_ctx),
        .spr_rdata(spr_rdata), .spr_ack(spr_ack), .spr_denied(spr_denied));
    // ****
    // tasks
    // ****
    task automatic end_of_test();
        if (mismatches == 0 && comparisons > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        comparisons++;
        if (got !== exp)
        begin
            mismatches++;
            $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    // bounded wait for a pulse
    task automatic wait_hi(ref logic s);
        int n = 0;
        do
        begin
            @(negedge clk_sys);
            n++;
        end
        while (s !== 1'b1 && n < 8);
        if (s !== 1'b1)
        begin
            mismatches++;
            end_of_test();
        end
    endtask
    // one register access, starts and ends at a rising edge
    task automatic spr_op(input logic w, input logic [15:0] a, input logic [31:0] d);
        spr <= '{we: w, re: !w, addr: a, wdata: d};
        @(posedge clk_sys);
        spr <= '0;
        wait_hi(spr_ack);
        q = spr_rdata;
        dq = spr_denied;
        @(posedge clk_sys);
    endtask
    task automatic rd(input logic [15:0] a, input logic [31:0] e, input logic den);
        spr_op(1'b0, a, 32'h0);
        chk(q, e);
        chk({31'h0, dq}, {31'h0, den});
    endtask
    task automatic seen(input logic [31:0] v, input logic [31:0] c);
        wait_hi(exc_valid);
        chk(exc_vector, v);
        chk(32'(exc_cause), c);
    endtask
    task automatic take(input logic [14:0] m, input logic [31:0] v, input logic [31:0] c);
        raise <= m;
        @(posedge clk_sys);
        raise <= 15'h0;
        seen(v, c);
        @(posedge clk_sys);
    endtask
    // ****
    // sequence
    // ****
    initial
    begin
        repeat (2) @(posedge clk_sys);
        resetn <= 1'b1;
        rd(`EXU_A_SW, 32'h0000_0001, 1'b0);
        rd(`EXU_A_CSW, 32'h0000_0000, 1'b0);
        rd(16'h0FFF, 32'h0000_0000, 1'b0);
        for (int i = 1; i < 15; i++)
        begin
            spr_op(1'b1, `EXU_A_SW, 32'h0000_0007);
            exc_ctx <= '{32'h1000 + 16 * i, 32'h1004 + 16 * i, 32'h8000 + i, 32'h9000 + i, i[0]};
            take(15'h1 << i, {20'h0, vec_k[i], 8'h00}, 32'(i));
            if (i < 5)
                exception_address_save = 32'h8000 + i;
            else if (i < 7 || i == 9 || i == 10)
                exception_address_save = 32'h9000 + i;
            epc = i[0] ? 32'h0FFC : (i == 7 || i > 11) ? 32'h1004 : 32'h1000;
            rd(16'h0020, epc + 16 * i, 1'b0);
            rd(16'h0030, exception_address_save, 1'b0);
            rd(16'h0040, 32'h0000_0007, 1'b0);
            rd(`EXU_A_SW, {17'h0, i[0], 14'h1}, 1'b0);
        end
        spr_op(1'b1, `EXU_A_SW, 32'h0000_0007);
        raise <= 15'h0184;
        @(posedge clk_sys);
        raise <= 15'h0;
        seen(32'h0000_0400, 32'(exu_pkg::EXU_IPF));
        seen(32'h0000_0C00, 32'(exu_pkg::EXU_SYS));
        seen(32'h0000_0E00, 32'(exu_pkg::EXU_TRAP));
        @(posedge clk_sys);
        spr_op(1'b1, `EXU_A_CSW, 32'h0003_0002);
        chk({16'h0, run_ctx}, 32'h0000_0003);
        spr_op(1'b1, `EXU_A_SW, 32'h0000_2001);
        exc_ctx <= '{32'h2000, 32'h2004, 32'h0, 32'h0, 1'b0};
        take(15'h0080, 32'h0000_0C00, 32'(exu_pkg::EXU_SYS));
        rd(`EXU_A_SW, 32'h1000_2001, 1'b0);
        rd(`EXU_A_CSW, 32'h0000_0003, 1'b0);
        rd(16'h0040, 32'h0000_2001, 1'b0);
        rfe <= 1'b1;
        @(posedge clk_sys);
        rfe <= 1'b0;
        wait_hi(rfe_valid);
        chk(rfe_pc, 32'h0000_2004);
        @(posedge clk_sys);
        rd(`EXU_A_SW, 32'h0000_2001, 1'b0);
        spr_op(1'b1, `EXU_A_SW, 32'hF000_2001);
        take(15'h0080, 32'h0000_0B00, 32'(exu_pkg::EXU_RANGE));
        rd(`EXU_A_SW, 32'hF000_2001, 1'b0);
        spr_op(1'b1, `EXU_A_CSW, 32'h0000_000F);
        rd(`EXU_A_SH_PCS, 32'h0000_2000, 1'b0);
        rd(`EXU_A_SH_STS, 32'hF000_2001, 1'b0);
        spr_op(1'b1, `EXU_A_SW, 32'h0000_0000);
        rd(`EXU_A_CSW, 32'h0000_0000, 1'b1);
        rd(`EXU_A_SH_PCS, 32'h0000_0000, 1'b1);
        spr_op(1'b1, `EXU_A_CSW, 32'h0009_0009);
        take(15'h0100, 32'h0000_0E00, 32'(exu_pkg::EXU_TRAP));
        rd(`EXU_A_CSW, 32'h0000_000F, 1'b0);
        take(15'h0001, 32'h0000_0100, 32'(exu_pkg::EXU_RST));
        rd(`EXU_A_SW, 32'h0000_0001, 1'b0);
        end_of_test();
    end
endmodule // exception_entry_and_context_switch_bench
